// ===== pkg/vmihp_pkg.sv
// constants and types of the host port block
package vmihp_pkg;
  // host-visible locations on the two address lines
  localparam logic [1:0] OFS_ADDR = 2'h0;
  localparam logic [1:0] OFS_DATA = 2'h1;
  localparam logic [1:0] OFS_FIFO = 2'h2;
  localparam logic [1:0] OFS_STAT = 2'h3;
  // internal address map landmarks
  localparam logic [7:0] IA_SLOW_LAST = 8'h8f;
  localparam logic [7:0] IA_UCODE_LOAD = 8'h7e;
  localparam logic [7:0] IA_UCODE_RUN = 8'h7f;
  localparam logic [7:0] IA_UCODE_READ = 8'h8e;
  localparam logic [7:0] IA_INT_ENABLE = 8'hc1;
  // field positions
  localparam int STAT_CC_BIT = 0;
  localparam int INTEN_CC_BIT = 0;
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] INTEN_RST = 8'h00;
  // strap patterns, bit 2 down to bit 0
  localparam logic [2:0] STRAP_MODE_B = 3'h6;
  localparam logic [2:0] STRAP_MODE_C = 3'h7;
  // longest internal access
  localparam int LATENCY_US = 64;
  localparam int CLK_MHZ = 100;
  localparam int LATENCY_CYCLES = LATENCY_US * CLK_MHZ;
  localparam int PRAM_AW = 11;
  typedef enum {HS_IDLE, HS_EXEC, HS_WAIT, HS_DONE} vmihp_hs_t;
endpackage : vmihp_pkg

// ===== pkg/vmihp_pram_if.sv
// program ram access bundle
`timescale 1ns/10ps
`default_nettype none
interface vmihp_pram_if #(parameter int AW = 11);
  logic wr;
  logic rd;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr, output rd, output addr, output wdata, input rdata);
  modport mem (input wr, input rd, input addr, input wdata, output rdata);
endinterface : vmihp_pram_if
`default_nettype wire

// ===== logic/vmihp_pram.sv
// program ram of the embedded microprocessor, registered read
`timescale 1ns/10ps
`default_nettype none
module vmihp_pram #(
  parameter int AW = 11
) (
  // clock
  input wire logic clock,
  // access
  vmihp_pram_if.mem p
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rdata;

  always_ff @(posedge clock) begin
    if (p.wr) begin
      mem[p.addr] <= p.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (p.rd) begin
      rdata <= mem[p.addr];
    end
  end

  assign p.rdata = rdata;
endmodule : vmihp_pram
`default_nettype wire

// ===== logic/vmihp_host_port.sv
// parallel host port: handshake, four-location map, indirect engine
`timescale 1ns/10ps
`default_nettype none
module vmihp_host_port #(
  parameter int LAT_CYCLES = vmihp_pkg::LATENCY_CYCLES,
  parameter int AW = vmihp_pkg::PRAM_AW
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // host pins
  input wire logic CHIP_SELECT_IN_N,
  input wire logic WRITE_STROBE_RW_IN,
  input wire logic READ_STROBE_DS_IN,
  input wire logic [1:0] HOST_ADDR,
  input wire logic [7:0] HOST_DATA_IN,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  output logic ACK_READY_OUT,
  output logic ACK_READY_OE,
  output logic INT_REQ_OUT,
  output logic INT_REQ_OE,
  // mode straps
  input wire logic MODE_STRAP_BIT2,
  input wire logic MODE_STRAP_BIT1,
  input wire logic MODE_STRAP_BIT0,
  // internal register bus
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_DONE,
  // teletext fifo
  output logic FIFO_RD,
  input wire logic [7:0] FIFO_DATA,
  // other interrupt sources, status bits 7..1
  input wire logic [6:0] STATUS_EVENTS,
  // embedded processor
  output logic MCU_RESET
);
  import vmihp_pkg::*;

  localparam int NSYNC = 16;
  localparam int TW = $clog2(LAT_CYCLES + 1);

  // pin synchronisers
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  assign pin_raw = {CHIP_SELECT_IN_N, WRITE_STROBE_RW_IN, READ_STROBE_DS_IN, HOST_ADDR,
                    HOST_DATA_IN, MODE_STRAP_BIT2, MODE_STRAP_BIT1, MODE_STRAP_BIT0};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge CLOCK) begin
        sync1[gi] <= pin_raw[gi];
        sync2[gi] <= sync1[gi];
      end
    end
  endgenerate

  logic cs;
  logic strb_a;
  logic strb_b;
  logic [1:0] pin_addr;
  logic [7:0] pin_data;
  logic [2:0] pin_strap;
  assign cs = ~sync2[15];
  assign strb_a = sync2[14];
  assign strb_b = sync2[13];
  assign pin_addr = sync2[12:11];
  assign pin_data = sync2[10:3];
  assign pin_strap = sync2[2:0];

  // strap capture while reset is held
  logic mode_b;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mode_b <= (pin_strap == STRAP_MODE_B);
    end
  end

  // cycle start, end and direction
  logic start;
  logic ended;
  logic pin_wr;
  always_comb begin
    if (mode_b) begin
      start = cs & (~strb_a | ~strb_b);
      ended = ~cs | (strb_a & strb_b);
      pin_wr = ~strb_a;
    end else begin
      start = cs & ~strb_b;
      ended = ~cs | strb_b;
      pin_wr = ~strb_a;
    end
  end

  vmihp_hs_t state;
  vmihp_hs_t next_state;
  logic [1:0] req_addr;
  logic [7:0] req_data;
  logic req_wr;

  // register state
  logic [7:0] indirect_address;
  logic [7:0] status_interrupt;
  logic [7:0] int_enable;
  logic [7:0] prefetch;
  logic [7:0] rdata;
  logic slow_busy;
  logic slow_rd;
  logic ram_pend;
  logic [AW-1:0] ptr;
  logic [TW-1:0] wait_cnt;
  logic timeout;

  vmihp_pram_if #(.AW(AW)) pram ();

  // decode of the request in execution
  logic exec;
  logic op_addr;
  logic op_win;
  logic op_fifo;
  logic op_stat;
  logic ia_slow;
  logic ia_special;
  logic new_slow;
  logic new_ucode;
  logic iss_rd;
  logic iss_wr;
  logic iss_slow;
  logic need_wait;
  logic cc_evt;
  assign exec = (state == HS_EXEC);
  assign op_addr = exec & (req_addr == OFS_ADDR) & req_wr;
  assign op_win = exec & (req_addr == OFS_DATA);
  assign op_fifo = exec & (req_addr == OFS_FIFO) & ~req_wr;
  assign op_stat = exec & (req_addr == OFS_STAT);
  assign ia_slow = (indirect_address <= IA_SLOW_LAST);
  assign ia_special = (indirect_address == IA_UCODE_LOAD) |
                      (indirect_address == IA_UCODE_RUN) |
                      (indirect_address == IA_UCODE_READ);
  assign new_ucode = (req_data == IA_UCODE_LOAD) | (req_data == IA_UCODE_READ);
  assign new_slow = (req_data <= IA_SLOW_LAST) & ~new_ucode & (req_data != IA_UCODE_RUN);
  // slow reads are prefetched at the address step, fast ones wait in the cycle
  assign iss_rd = (op_addr & new_slow) | (op_win & ~req_wr & ~ia_slow);
  assign iss_wr = op_win & req_wr & ~ia_special;
  assign iss_slow = (op_addr & new_slow) | (iss_wr & ia_slow);
  assign need_wait = op_win & ~ia_slow;
  assign FIFO_RD = op_fifo;

  always_comb begin
    next_state = state;
    case (state)
      HS_IDLE: begin
        if (start) begin
          next_state = HS_EXEC;
        end
      end
      HS_EXEC: begin
        next_state = need_wait ? HS_WAIT : HS_DONE;
      end
      HS_WAIT: begin
        if (REG_DONE | timeout) begin
          next_state = HS_DONE;
        end
      end
      HS_DONE: begin
        if (ended) begin
          next_state = HS_IDLE;
        end
      end
      default: begin
        next_state = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= HS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request capture at the strobe edge
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      req_addr <= OFS_ADDR;
      req_data <= 8'h00;
      req_wr <= 1'b0;
    end else if (state == HS_IDLE && start) begin
      req_addr <= pin_addr;
      req_data <= pin_data;
      req_wr <= pin_wr;
    end
  end

  // address register, kept across window accesses
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      indirect_address <= ADDR_RST;
    end else if (op_addr) begin
      indirect_address <= req_data;
    end
  end

  // internal bus strobes, one cycle each
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      REG_RD <= 1'b0;
      REG_WR <= 1'b0;
      REG_ADDR <= 8'h00;
      REG_WDATA <= 8'h00;
    end else begin
      REG_RD <= iss_rd;
      REG_WR <= iss_wr;
      if (iss_rd | iss_wr) begin
        REG_ADDR <= op_addr ? req_data : indirect_address;
        REG_WDATA <= req_data;
      end
    end
  end

  // latency guard shared by slow and fast waits
  assign timeout = (wait_cnt == TW'(LAT_CYCLES));
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || !(slow_busy || state == HS_WAIT)) begin
      wait_cnt <= '0;
    end else if (!timeout) begin
      wait_cnt <= wait_cnt + TW'(1);
    end
  end

  // background slow access
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      slow_busy <= 1'b0;
      slow_rd <= 1'b0;
      prefetch <= 8'h00;
    end else if (iss_slow) begin
      slow_busy <= 1'b1;
      slow_rd <= op_addr;
    end else if (slow_busy && (REG_DONE || timeout)) begin
      slow_busy <= 1'b0;
      if (slow_rd) begin
        prefetch <= REG_RDATA;
      end
    end
  end

  // processor reset and program ram pointer
  logic [AW-1:0] ptr_base;
  assign ptr_base = MCU_RESET ? ptr : '0;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      MCU_RESET <= 1'b0;
      ptr <= '0;
    end else if (op_addr && new_ucode) begin
      MCU_RESET <= 1'b1;
      // each 8e load fetches one byte and steps the pointer
      ptr <= (req_data == IA_UCODE_READ) ? ptr_base + AW'(1) : ptr_base;
    end else if (op_win && req_wr && indirect_address == IA_UCODE_RUN) begin
      MCU_RESET <= 1'b0;
    end else if (op_win && req_wr && indirect_address == IA_UCODE_LOAD) begin
      ptr <= ptr + AW'(1);
    end
  end

  assign pram.wr = op_win & req_wr & (indirect_address == IA_UCODE_LOAD);
  assign pram.rd = op_addr & (req_data == IA_UCODE_READ);
  assign pram.addr = pram.rd ? ptr_base : ptr;
  assign pram.wdata = req_data;

  vmihp_pram #(.AW(AW)) u_pram (
    .clock(CLOCK),
    .p(pram)
  );

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ram_pend <= 1'b0;
    end else begin
      ram_pend <= pram.wr | pram.rd;
    end
  end

  // completion of a background slow access or a program ram access
  assign cc_evt = ram_pend | (slow_busy & (REG_DONE | timeout));

  // interrupt enable shadow, also forwarded on the internal bus
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      int_enable <= INTEN_RST;
    end else if (iss_wr && indirect_address == IA_INT_ENABLE) begin
      int_enable <= req_data;
    end
  end

  // sticky status, a new event beats a same-cycle clear
  logic [7:0] stat_set;
  logic [7:0] stat_clr;
  assign stat_set = {STATUS_EVENTS, cc_evt};
  assign stat_clr = (op_stat && req_wr) ? req_data : 8'h00;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      status_interrupt <= STAT_RST;
    end else begin
      status_interrupt <= (status_interrupt & ~stat_clr) | stat_set;
    end
  end

  // open-drain interrupt request, pulled low while a status bit is set; bit 0 only while enabled
  logic [7:0] irq_mask;
  assign irq_mask = {7'h7f, int_enable[INTEN_CC_BIT]};
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      INT_REQ_OE <= 1'b0;
    end else begin
      INT_REQ_OE <= |(status_interrupt & irq_mask);
    end
  end
  assign INT_REQ_OUT = 1'b0;

  // read data
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata <= 8'h00;
    end else if (exec && !req_wr) begin
      case (req_addr)
        OFS_DATA: begin
          rdata <= (indirect_address == IA_UCODE_READ) ? pram.rdata : prefetch;
        end
        OFS_FIFO: begin
          rdata <= FIFO_DATA;
        end
        OFS_STAT: begin
          rdata <= status_interrupt;
        end
        default: begin
          rdata <= 8'h00;
        end
      endcase
    end else if (state == HS_WAIT && REG_DONE) begin
      rdata <= REG_RDATA;
    end
  end
  assign HOST_DATA_OUT = rdata;

  // ack/ready and bus drive
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ACK_READY_OUT <= 1'b1;
      ACK_READY_OE <= 1'b0;
      HOST_DATA_OE <= 1'b0;
    end else begin
      if (mode_b) begin
        // low only while the access is in progress
        ACK_READY_OUT <= ~(next_state == HS_EXEC || next_state == HS_WAIT);
      end else begin
        ACK_READY_OUT <= ~(next_state == HS_DONE);
      end
      ACK_READY_OE <= cs;
      HOST_DATA_OE <= cs & ~req_wr & (next_state == HS_DONE);
    end
  end
endmodule : vmihp_host_port
`default_nettype wire

// ===== test/vmihp_host_port_props.sv
// concurrent checks on the host port pins
`timescale 1ns/10ps
`default_nettype none
module vmihp_host_port_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // host pins
  input wire logic CHIP_SELECT_IN_N,
  input wire logic WRITE_STROBE_RW_IN,
  input wire logic [1:0] HOST_ADDR,
  input wire logic HOST_DATA_OE,
  input wire logic ACK_READY_OUT,
  input wire logic ACK_READY_OE,
  input wire logic INT_REQ_OE,
  // inner side
  input wire logic [6:0] STATUS_EVENTS,
  input wire logic FIFO_RD,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic MCU_RESET
);
  import vmihp_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // two sync flops plus the output register
  chk_ack_released: assert property (CHIP_SELECT_IN_N [*4] |-> !ACK_READY_OE)
    else $error("ack pin driven while deselected");
  chk_data_released: assert property (CHIP_SELECT_IN_N [*4] |-> !HOST_DATA_OE)
    else $error("data bus driven while deselected");
  chk_fifo_pop_src: assert property (FIFO_RD |->
    HOST_ADDR == OFS_FIFO && !CHIP_SELECT_IN_N && WRITE_STROBE_RW_IN)
    else $error("fifo popped outside a fifo read");
  chk_fifo_pop_once: assert property (FIFO_RD |=> !FIFO_RD [*6])
    else $error("fifo popped twice in one cycle");
  chk_reg_strobe_once: assert property ((REG_WR || REG_RD) |=> !(REG_WR || REG_RD))
    else $error("internal strobe longer than a pulse");
  chk_reg_write_src: assert property (REG_WR |->
    HOST_ADDR == OFS_DATA && !WRITE_STROBE_RW_IN && !CHIP_SELECT_IN_N)
    else $error("internal write without window write");
  chk_mcu_halt_src: assert property ($rose(MCU_RESET) |->
    HOST_ADDR == OFS_ADDR && !CHIP_SELECT_IN_N)
    else $error("processor halted without address write");
  chk_mcu_run_src: assert property ($fell(MCU_RESET) |->
    HOST_ADDR == OFS_DATA && !CHIP_SELECT_IN_N)
    else $error("processor released without window write");
  chk_event_irq: assert property (|STATUS_EVENTS |-> ##[1:2] INT_REQ_OE)
    else $error("event did not raise interrupt");
  chk_irq_sticky: assert property (INT_REQ_OE && CHIP_SELECT_IN_N |=> INT_REQ_OE)
    else $error("status bit cleared without host write");
  chk_ack_in_cycle: assert property ($fell(ACK_READY_OUT) |-> !CHIP_SELECT_IN_N)
    else $error("ack outside a host cycle");
  cov_fifo: cover property (FIFO_RD);
  cov_halt: cover property ($rose(MCU_RESET));
  cov_irq: cover property ($rose(INT_REQ_OE));
endmodule : vmihp_host_port_chk
bind vmihp_host_port vmihp_host_port_chk u_chk (.CLOCK, .SYS_RST, .CHIP_SELECT_IN_N,
  .WRITE_STROBE_RW_IN, .HOST_ADDR, .HOST_DATA_OE, .ACK_READY_OUT, .ACK_READY_OE,
  .INT_REQ_OE, .STATUS_EVENTS, .FIFO_RD, .REG_WR, .REG_RD, .MCU_RESET);
`default_nettype wire

// ===== test/vmihp_host_model.sv
// host processor model for both handshake modes
`timescale 1ns/10ps
`default_nettype none
module vmihp_host_model (
  // clock and mode
  input wire logic clk,
  input wire logic mode_b,
  // device answer
  input wire logic ack,
  input wire logic ack_oe,
  input wire logic [7:0] dout,
  input wire logic dout_oe,
  // host drive
  output logic cs_n,
  output logic ws,
  output logic rs,
  output logic [1:0] addr,
  output logic [7:0] din
);
  logic ack_pin;
  logic [7:0] bus_in;
  // undriven data bus reads as garbage, so a late or missing drive shows up
  assign bus_in = dout_oe ? dout : ~dout;
  // pulled up when released
  assign ack_pin = ack_oe ? ack : 1'b1;
  initial begin
    cs_n = 1'b1;
    ws = 1'b1;
    rs = 1'b1;
    addr = 2'h0;
    din = 8'h00;
  end
  task automatic xfer(input logic we, input logic [1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n = 0;
    @(posedge clk);
    cs_n <= 1'b0;
    addr <= a;
    din <= d;
    ws <= mode_b | !we;
    @(posedge clk);
    ws <= !we;
    rs <= mode_b & we;
    do begin
      @(posedge clk);
      n++;
    end while (ack_pin !== 1'b0 && n < 200);
    // strobe-select: low means busy, so wait for the release
    while (mode_b && ack_pin !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    q = (n < 200) ? bus_in : 8'hxx;
    ws <= 1'b1;
    rs <= 1'b1;
    cs_n <= 1'b1;
    din <= ~d;
    repeat (4) @(posedge clk);
  endtask : xfer
endmodule : vmihp_host_model
`default_nettype wire

// ===== test/tb_top.sv
// bench for the host port in both handshake modes
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import vmihp_pkg::*;
  logic clock = 0;
  logic sys_rst = 1;
  logic s2 = 1, s1 = 1, s0 = 1;
  wire logic cs_n, ws, rs;
  wire logic [1:0] ha;
  wire logic [7:0] hdi;
  logic hdoe, ack, ackoe, intr, intoe, rwr, rrd, frd, mcu, rdone = 0;
  logic [7:0] hdo, ra, rwd, rdat = 0, fdata = 8'h30, la = 0, wa = 0, wd = 0;
  logic [6:0] ev = 0;
  int cnt = 0, n, num_errors = 0, compares = 0;
  always #5 clock = ~clock;
  vmihp_host_port #(.LAT_CYCLES(40)) dut (.CLOCK(clock), .SYS_RST(sys_rst),
    .CHIP_SELECT_IN_N(cs_n), .WRITE_STROBE_RW_IN(ws), .READ_STROBE_DS_IN(rs),
    .HOST_ADDR(ha), .HOST_DATA_IN(hdi), .HOST_DATA_OUT(hdo), .HOST_DATA_OE(hdoe),
    .ACK_READY_OUT(ack), .ACK_READY_OE(ackoe), .INT_REQ_OUT(intr), .INT_REQ_OE(intoe),
    .MODE_STRAP_BIT2(s2), .MODE_STRAP_BIT1(s1), .MODE_STRAP_BIT0(s0),
    .REG_ADDR(ra), .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rdat),
    .REG_DONE(rdone), .FIFO_RD(frd), .FIFO_DATA(fdata), .STATUS_EVENTS(ev),
    .MCU_RESET(mcu));
  vmihp_host_model host (.clk(clock), .mode_b(!s0), .ack(ack), .ack_oe(ackoe),
    .dout(hdo), .dout_oe(hdoe), .cs_n(cs_n), .ws(ws), .rs(rs), .addr(ha), .din(hdi));
  // slow locations answer late but well inside the timeout
  always @(posedge clock) begin
    rdone <= (cnt == 1);
    rdat <= (cnt == 1) ? la ^ 8'h5a : ~(la ^ 8'h5a);
    if (rwr || rrd) begin
      la <= ra;
      cnt <= (ra <= IA_SLOW_LAST) ? 12 : 2;
    end else if (cnt > 0) cnt <= cnt - 1;
    if (rwr) begin
      wa <= ra;
      wd <= rwd;
    end
    if (frd) fdata <= fdata + 8'h01;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, a, d, q);
    chk({7'h00, $isunknown(q)}, 8'h00);
  endtask : wr
  task rd(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'hc3, q);
    chk(q, e);
  endtask : rd
  task wait_cc;
    logic [7:0] q;
    int k;
    k = 0;
    do begin
      host.xfer(1'b0, OFS_STAT, 8'hc3, q);
      k++;
    end while (q[STAT_CC_BIT] !== 1'b1 && k < 60);
    chk(q & 8'h01, 8'h01);
    wr(OFS_STAT, 8'h01);
  endtask : wait_cc
  task rst;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : rst
  task results;
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    results();
  end
  initial begin
    rst();
    rd(OFS_STAT, 8'h00);
    rd(OFS_ADDR, 8'h00);
    wr(OFS_ADDR, 8'h95);
    wr(OFS_DATA, 8'hab);
    chk(wa, 8'h95);
    chk(wd, 8'hab);
    rd(OFS_DATA, 8'h95 ^ 8'h5a);
    rd(OFS_STAT, 8'h00);
    wr(OFS_ADDR, 8'h10);
    wait_cc();
    rd(OFS_DATA, 8'h10 ^ 8'h5a);
    rd(OFS_STAT, 8'h00);
    @(posedge clock);
    ev <= 7'h05;
    @(posedge clock);
    ev <= 7'h00;
    rd(OFS_STAT, 8'h0a);
    chk({7'h00, intoe}, 8'h01);
    wr(OFS_STAT, 8'h02);
    rd(OFS_STAT, 8'h08);
    wr(OFS_STAT, 8'h08);
    chk({7'h00, intoe}, 8'h00);
    wr(OFS_ADDR, IA_INT_ENABLE);
    wr(OFS_DATA, 8'h01);
    wr(OFS_ADDR, 8'h20);
    wait_cc();
    wr(OFS_DATA, 8'h77);
    chk(wd, 8'h77);
    for (n = 0; n < 100 && intoe !== 1'b1; n++) @(posedge clock);
    chk({7'h00, intoe}, 8'h01);
    chk({7'h00, intr}, 8'h00);
    rd(OFS_STAT, 8'h01);
    wr(OFS_STAT, 8'h01);
    chk({7'h00, intoe}, 8'h00);
    rd(OFS_FIFO, 8'h30);
    rd(OFS_FIFO, 8'h31);
    wr(OFS_FIFO, 8'h55);
    rd(OFS_FIFO, 8'h32);
    wr(OFS_ADDR, IA_UCODE_LOAD);
    chk({7'h00, mcu}, 8'h01);
    wr(OFS_DATA, 8'ha1);
    wait_cc();
    wr(OFS_DATA, 8'hb2);
    wait_cc();
    wr(OFS_ADDR, IA_UCODE_RUN);
    wr(OFS_DATA, 8'h00);
    chk({7'h00, mcu}, 8'h00);
    for (n = 0; n < 2; n++) begin
      wr(OFS_ADDR, IA_UCODE_READ);
      wait_cc();
      rd(OFS_DATA, (n == 1) ? 8'hb2 : 8'ha1);
    end
    chk({7'h00, mcu}, 8'h01);
    wr(OFS_ADDR, IA_UCODE_RUN);
    wr(OFS_DATA, 8'h3c);
    chk({7'h00, mcu}, 8'h00);
    s0 <= 1'b0;
    rst();
    wr(OFS_ADDR, 8'h9a);
    rd(OFS_DATA, 8'h9a ^ 8'h5a);
    rd(OFS_STAT, 8'h00);
    results();
  end
endmodule : tb_top
`default_nettype wire
